// file: urs_rx_status.sv
/*
 * receive status, buffer and interrupt logic of an asynchronous serial port.
 * assumes a receive shift register outside that hands over finished characters
 * with their error marks and reports when a frame is in progress.
 */
// Added by the designer: register access over Wishbone and the placing of the registers.
// Summary of operation
// R01: level select asserts level interrupt at not empty, half, or three quarters full.
// R02: in address mode a character with ninth bit one is an address character.
// R03: address detect enable is ignored unless nine-bit format is selected.
// R04: idle flag reads one when no character is arriving, else zero.
// R05: parity error flag shows parity error of current character.
// R06: framing error flag shows framing error of current character.
// R07: overrun sets on buffer overflow; only a software write of zero clears.
// R08: clearing a set overrun empties the buffer and the shift register.
// R09: data available reads one whenever the buffer holds a character.
// R10: format code three selects nine data bits without parity.
// R11: address compare uses only bits whose mask bit is one.
// R12: buffer holds four characters; half is two, three quarters is three.
// R13: error flags follow the character at the buffer read head.
`timescale 1ns/1ps
module urs_rx_status #(
    parameter int DEPTH = urs_pkg::RX_DEPTH
) (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_b,
    // wishbone slave
    input  wire logic                    wb_cyc,
    input  wire logic                    wb_stb,
    input  wire logic                    wb_we,
    input  wire logic [4:0]              wb_adr,
    input  wire logic [3:0]              wb_sel,
    input  wire logic [31:0]             wb_dat_w,
    output logic      [31:0]             wb_dat_r,
    output logic                         wb_ack,
    // receive shift register side
    input  wire logic                    rx_busy,
    input  wire logic                    rx_char_valid,
    input  wire urs_pkg::urs_char_t      rx_char,
    output logic                         rx_shift_flush_ff,
    output urs_pkg::urs_fmt_t            data_format_select_ff,
    // interrupt
    output logic                         irq_ff
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least four");
    end

    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_CNT = CW'(DEPTH / 2);
    localparam logic [CW-1:0] TQ_CNT   = CW'((DEPTH * 3) / 4);
    localparam logic [CW-1:0] ONE_CNT  = CW'(1);

    // R01 fill thresholds per code
    function automatic logic level_hit(input urs_pkg::urs_isel_t sel, input logic [CW-1:0] cnt);
        case (sel)
            urs_pkg::ISEL_NOT_EMPTY: level_hit = (cnt >= ONE_CNT);
            urs_pkg::ISEL_HALF:      level_hit = (cnt >= HALF_CNT);
            urs_pkg::ISEL_3QUARTER:  level_hit = (cnt >= TQ_CNT);
            default:                 level_hit = 1'b0;
        endcase
    endfunction : level_hit

    function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] ref_addr,
                                        input logic [7:0] mask);
        addr_match = ((rx ^ ref_addr) & mask) == urs_pkg::RST_BYTE;
    endfunction : addr_match

    function automatic logic [7:0] lane(input logic [7:0] old, input logic en, input logic [7:0] val);
        lane = en ? val : old;
    endfunction : lane

    // registers
    logic [7:0]                 addr_mask_ff;
    logic [7:0]                 match_addr_ff;
    urs_pkg::urs_isel_t         rx_irq_level_select_ff;
    logic                       addr_detect_enable_ff;
    logic                       rx_idle_flag_ff;
    logic                       rx_overrun_flag_ff;
    logic                       addr_matched_ff;
    logic                       level_prev_ff;
    logic [urs_pkg::IRQ_W-1:0]  irq_status_ff;
    logic [urs_pkg::IRQ_W-1:0]  irq_mask_ff;
    logic [AW-1:0]              wr_ptr_ff;
    logic [AW-1:0]              rd_ptr_ff;
    logic [CW-1:0]              count_ff;

    // bus decode
    logic req;
    logic rd_req;
    logic wr_req;
    assign req    = wb_cyc && wb_stb && !wb_ack;
    assign rd_req = req && !wb_we;
    assign wr_req = req && wb_we;

    // buffer control
    logic                       addr_mode;
    logic                       is_addr_char;
    logic                       accept;
    logic                       full;
    logic                       empty;
    logic                       push;
    logic                       overflow;
    logic                       pop;
    logic                       overrun_clear;
    logic                       level_now;
    logic [AW-1:0]              nxt_rd_ptr;
    logic [urs_pkg::IRQ_W-1:0]  irq_events;
    logic [urs_pkg::ENTRY_W-1:0] head_raw;
    urs_pkg::urs_char_t         head;

    // R03 address mode only in nine-bit format
    // R10 format code three is nine bits
    assign addr_mode    = addr_detect_enable_ff && (data_format_select_ff == urs_pkg::FMT_9N);
    // R02 ninth bit marks an address
    assign is_addr_char = rx_char.data[urs_pkg::NINTH_BIT];
    // R11 masked address compare
    assign accept = !addr_mode ? 1'b1 :
                    is_addr_char ? addr_match(rx_char.data[7:0], match_addr_ff, addr_mask_ff) :
                    addr_matched_ff;

    assign full     = (count_ff == FULL_CNT);
    assign empty    = (count_ff == '0);
    assign push     = rx_char_valid && accept && !full;
    assign overflow = rx_char_valid && accept && full;
    assign pop      = rd_req && (wb_adr == urs_pkg::OFS_RX_DATA) && !empty;
    // R07 only a written zero clears; a new overflow in the same cycle wins
    assign overrun_clear = wr_req && (wb_adr == urs_pkg::OFS_STATUS_CONTROL) && wb_sel[0]
                           && !wb_dat_w[urs_pkg::RX_OVERRUN_FLAG_BIT] && rx_overrun_flag_ff && !overflow;
    assign nxt_rd_ptr    = overrun_clear ? '0 : (pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff);
    assign level_now     = level_hit(rx_irq_level_select_ff, count_ff);
    assign head          = urs_pkg::urs_char_t'(head_raw);

    always_comb begin
        irq_events = '0;
        irq_events[urs_pkg::IRQ_LEVEL]    = level_now && !level_prev_ff;
        irq_events[urs_pkg::IRQ_ADDR]     = rx_char_valid && addr_mode && is_addr_char && accept;
        irq_events[urs_pkg::IRQ_OVERRUN]  = overflow;
        irq_events[urs_pkg::IRQ_CHAR_ERR] = push && (rx_char.parity_error_flag || rx_char.framing_error_flag);
    end

    // R12 four-entry buffer storage
    urs_rx_mem #(
        .WIDTH (urs_pkg::ENTRY_W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .core_clk (core_clk),
        .we       (push),
        .waddr    (wr_ptr_ff),
        .wdata    (rx_char),
        .raddr    (nxt_rd_ptr),
        .rdata    (head_raw)
    );

    // buffer pointers and fill count
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        // R08 clearing overrun empties the buffer
        end else if (overrun_clear) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            rd_ptr_ff <= nxt_rd_ptr;
            if (push) begin
                wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
            end
            count_ff <= CW'(count_ff + CW'(push) - CW'(pop));
        end
    end

    // R08 shift register flushed together with the buffer
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rx_shift_flush_ff <= 1'b0;
        end else begin
            rx_shift_flush_ff <= overrun_clear;
        end
    end

    // R07 overrun flag set by hardware, cleared by software only
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rx_overrun_flag_ff <= 1'b0;
        end else if (overflow) begin
            rx_overrun_flag_ff <= 1'b1;
        end else if (overrun_clear) begin
            rx_overrun_flag_ff <= 1'b0;
        end
    end

    // R04 idle follows the shift register activity
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rx_idle_flag_ff <= 1'b1;
        end else begin
            rx_idle_flag_ff <= !rx_busy;
        end
    end

    // address match state: data characters pass only after a matching address
    always_ff @(posedge core_clk) begin
        if (!rst_b || !addr_mode) begin
            addr_matched_ff <= 1'b0;
        end else if (rx_char_valid && is_addr_char) begin
            addr_matched_ff <= accept;
        end
    end

    // control fields written by software
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            addr_mask_ff           <= urs_pkg::RST_BYTE;
            match_addr_ff          <= urs_pkg::RST_BYTE;
            rx_irq_level_select_ff <= urs_pkg::ISEL_NOT_EMPTY;
            addr_detect_enable_ff  <= 1'b0;
            data_format_select_ff  <= urs_pkg::FMT_8N;
            irq_mask_ff            <= urs_pkg::RST_IRQ;
        end else if (wr_req) begin
            case (wb_adr)
                urs_pkg::OFS_STATUS_CONTROL: begin
                    addr_mask_ff  <= lane(addr_mask_ff, wb_sel[3], wb_dat_w[urs_pkg::MASK_LSB +: 8]);
                    match_addr_ff <= lane(match_addr_ff, wb_sel[2], wb_dat_w[urs_pkg::ADDR_LSB +: 8]);
                    if (wb_sel[0]) begin
                        rx_irq_level_select_ff <= urs_pkg::urs_isel_t'(wb_dat_w[urs_pkg::ISEL_LSB +: 2]);
                        addr_detect_enable_ff  <= wb_dat_w[urs_pkg::ADDR_DETECT_ENABLE_BIT];
                    end
                end
                urs_pkg::OFS_FORMAT: begin
                    if (wb_sel[0]) begin
                        data_format_select_ff <= urs_pkg::urs_fmt_t'(wb_dat_w[1:0]);
                    end
                end
                urs_pkg::OFS_IRQ_MASK: begin
                    if (wb_sel[0]) begin
                        irq_mask_ff <= wb_dat_w[urs_pkg::IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // sticky events; a read clears, but an event in that cycle survives
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irq_status_ff <= urs_pkg::RST_IRQ;
            level_prev_ff <= 1'b0;
        end else begin
            level_prev_ff <= level_now;
            if (rd_req && (wb_adr == urs_pkg::OFS_IRQ_STATUS)) begin
                irq_status_ff <= irq_events;
            end else begin
                irq_status_ff <= irq_status_ff | irq_events;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // read data; rx data reads as zero when the buffer is empty
    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = '0;
        case (wb_adr)
            urs_pkg::OFS_STATUS_CONTROL: begin
                nxt_rdata[urs_pkg::MASK_LSB +: 8] = addr_mask_ff;
                nxt_rdata[urs_pkg::ADDR_LSB +: 8] = match_addr_ff;
                nxt_rdata[urs_pkg::ISEL_LSB +: 2] = rx_irq_level_select_ff;
                nxt_rdata[urs_pkg::ADDR_DETECT_ENABLE_BIT]     = addr_detect_enable_ff;
                nxt_rdata[urs_pkg::RX_IDLE_FLAG_BIT]     = rx_idle_flag_ff;
                // R05 R13 parity mark of the head character
                nxt_rdata[urs_pkg::PARITY_ERROR_FLAG_BIT]      = !empty && head.parity_error_flag;
                // R06 R13 framing mark of the head character
                nxt_rdata[urs_pkg::FRAMING_ERROR_FLAG_BIT]      = !empty && head.framing_error_flag;
                nxt_rdata[urs_pkg::RX_OVERRUN_FLAG_BIT]      = rx_overrun_flag_ff;
                // R09 data available
                nxt_rdata[urs_pkg::RXDA_BIT]      = !empty;
            end
            urs_pkg::OFS_FORMAT:     nxt_rdata[1:0] = data_format_select_ff;
            urs_pkg::OFS_RX_DATA:    nxt_rdata[urs_pkg::CHAR_W-1:0] = empty ? '0 : head.data;
            urs_pkg::OFS_IRQ_STATUS: nxt_rdata[urs_pkg::IRQ_W-1:0] = irq_status_ff;
            urs_pkg::OFS_IRQ_MASK:   nxt_rdata[urs_pkg::IRQ_W-1:0] = irq_mask_ff;
            default:                 nxt_rdata = '0;
        endcase
    end

    // single wait-free answer: ack one cycle after the request, unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wb_ack   <= 1'b0;
            wb_dat_r <= '0;
        end else begin
            wb_ack   <= req;
            wb_dat_r <= rd_req ? nxt_rdata : '0;
        end
    end

    // R01 level interrupt thresholds
    a_level_two_half: assert property (@(posedge core_clk) disable iff (!rst_b)  // R01
        (rx_irq_level_select_ff == urs_pkg::ISEL_HALF && count_ff == HALF_CNT && $stable(count_ff))
        |-> level_now)
        else $error("half level not signalled at two characters");
    a_level_reserved: assert property (@(posedge core_clk) disable iff (!rst_b)  // R01
        (rx_irq_level_select_ff == urs_pkg::ISEL_RESERVED) |-> !irq_events[urs_pkg::IRQ_LEVEL])
        else $error("reserved level select raised an event");
    a_addr_needs_nine: assert property (@(posedge core_clk) disable iff (!rst_b)  // R03
        (rx_char_valid && data_format_select_ff != urs_pkg::FMT_9N && !full) |-> push)
        else $error("character dropped outside nine-bit mode");
    a_addr_drop_data: assert property (@(posedge core_clk) disable iff (!rst_b)  // R02
        (rx_char_valid && addr_mode && !is_addr_char && !addr_matched_ff) |-> !push)
        else $error("data accepted before any address match");
    a_idle_follow: assert property (@(posedge core_clk) disable iff (!rst_b)  // R04
        rx_busy[*2] |-> !rx_idle_flag_ff)
        else $error("idle flag high while busy");
    a_overrun_set: assert property (@(posedge core_clk) disable iff (!rst_b)  // R07
        overflow |=> rx_overrun_flag_ff && (count_ff == ($past(pop) ? FULL_CNT - ONE_CNT : FULL_CNT)))
        else $error("overflow did not set overrun");
    a_overrun_hold: assert property (@(posedge core_clk) disable iff (!rst_b)  // R07
        (rx_overrun_flag_ff && !wr_req) |=> rx_overrun_flag_ff)
        else $error("overrun cleared without a write");
    a_flush_empty: assert property (@(posedge core_clk) disable iff (!rst_b)  // R08
        overrun_clear |=> (count_ff == '0) && rx_shift_flush_ff ##1 !rx_shift_flush_ff || overrun_clear)
        else $error("overrun clear did not flush");
    a_count_bound: assert property (@(posedge core_clk) disable iff (!rst_b)  // R12
        count_ff <= FULL_CNT)
        else $error("buffer count beyond depth");
    a_rxda_read: assert property (@(posedge core_clk) disable iff (!rst_b)  // R09
        (rd_req && wb_adr == urs_pkg::OFS_STATUS_CONTROL) |=> wb_ack && (wb_dat_r[urs_pkg::RXDA_BIT] == ($past(count_ff) != '0)))
        else $error("data available disagrees with count");
    a_ack_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
        wb_ack |=> !wb_ack)
        else $error("ack held two cycles");

endmodule : urs_rx_status

// file: urs_pkg.sv
/*
 * shared constants and types of the receive status and interrupt block:
 * register offsets, field positions, reset values, modes and carriers.
 * assumes a 32-bit classic wishbone register bus and a 40 MHz core clock.
 */
package urs_pkg;

    // register byte offsets
    localparam logic [4:0] OFS_STATUS_CONTROL = 5'h00;
    localparam logic [4:0] OFS_FORMAT         = 5'h04;
    localparam logic [4:0] OFS_RX_DATA        = 5'h08;
    localparam logic [4:0] OFS_IRQ_STATUS     = 5'h0c;
    localparam logic [4:0] OFS_IRQ_MASK       = 5'h10;

    // fields of the status and control register
    localparam int MASK_LSB    = 24;
    localparam int ADDR_LSB    = 16;
    localparam int ISEL_LSB    = 6;
    localparam int ADDR_DETECT_ENABLE_BIT   = 5;
    localparam int RX_IDLE_FLAG_BIT   = 4;
    localparam int PARITY_ERROR_FLAG_BIT    = 3;
    localparam int FRAMING_ERROR_FLAG_BIT    = 2;
    localparam int RX_OVERRUN_FLAG_BIT    = 1;
    localparam int RXDA_BIT    = 0;
    localparam int NINTH_BIT   = 8;

    // sticky interrupt bits
    localparam int IRQ_W        = 4;
    localparam int IRQ_LEVEL    = 0;
    localparam int IRQ_ADDR     = 1;
    localparam int IRQ_OVERRUN  = 2;
    localparam int IRQ_CHAR_ERR = 3;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_FMT  = 2'h0;
    localparam logic [3:0] RST_IRQ  = 4'h0;

    localparam int CHAR_W = 9;
    localparam int RX_DEPTH = 4;

    typedef enum logic [1:0] {
        ISEL_NOT_EMPTY = 2'h0,
        ISEL_HALF      = 2'h1,
        ISEL_3QUARTER  = 2'h2,
        ISEL_RESERVED  = 2'h3
    } urs_isel_t;

    typedef enum logic [1:0] {
        FMT_8N   = 2'h0,
        FMT_8E   = 2'h1,
        FMT_8O   = 2'h2,
        FMT_9N   = 2'h3
    } urs_fmt_t;

    // one received character with its error marks
    typedef struct packed {
        logic              framing_error_flag;
        logic              parity_error_flag;
        logic [CHAR_W-1:0] data;
    } urs_char_t;

    localparam int ENTRY_W = $bits(urs_char_t);

endpackage : urs_pkg

// file: urs_rx_mem.sv
/*
 * small receive buffer storage: one write port, one read port whose data
 * come out of a register. assumes the caller keeps the pointers in range.
 */
`timescale 1ns/1ps
module urs_rx_mem #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    // clock
    input  wire logic             core_clk,
    // write side
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // read side
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // bypass so a word written into an empty buffer is visible at once
    always_ff @(posedge core_clk) begin
        if (we && (waddr == raddr)) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule : urs_rx_mem

// file: urs_far_tx.sv
/*
 * behavioural model of the receive shift register feeding the status block:
 * frames a character with a busy window, then hands it over for one cycle unless a flush came during the window.
 * assumes frame() is called right after a rising core_clk edge.
 */
`timescale 1ns/1ps
module urs_far_tx (
    // clock
    input  wire logic         core_clk,
    // flush request from the block
    input  wire logic         rx_shift_flush_ff,
    // toward the block
    output logic              rx_busy,
    output logic              rx_char_valid,
    output urs_pkg::urs_char_t rx_char
);
    initial begin
        rx_busy       = 1'b0;
        rx_char_valid = 1'b0;
        rx_char       = '0;
    end

    task automatic frame(input urs_pkg::urs_char_t c, input int len);
        bit abort;
        abort = 1'b0;
        rx_busy <= 1'b1;
        for (int i = 0; i < len; i++) begin
            @(posedge core_clk);
            if (rx_shift_flush_ff === 1'b1) abort = 1'b1;
        end
        rx_busy       <= 1'b0;
        rx_char_valid <= !abort;
        rx_char       <= c;
        @(posedge core_clk);
        rx_char_valid <= 1'b0;
        // stale data is never left on the lines between frames
        rx_char       <= ~c;
    endtask : frame
endmodule : urs_far_tx

// file: tb_top.sv
/*
 * self-checking bench of the receive status block: reads are scoreboarded.
 * assumes the design and its package are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
    logic               core_clk, rst_b, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [4:0]         wb_adr;
    logic [3:0]         wb_sel;
    logic [31:0]        wb_dat_w, wb_dat_r, ctl;
    logic [31:0]        exp_q[$], care_q[$];
    logic               rx_busy, rx_char_valid, rx_shift_flush_ff, irq_ff;
    urs_pkg::urs_char_t rx_char;
    urs_pkg::urs_fmt_t  fmt;
    logic [8:0]         dq[$];
    logic [9:0]         atab[5] = '{10'h033, 10'h35a, 10'h244, 10'h1a0, 10'h077};
    int                 n_fail, samples_checked, n_flush, cycles;

    urs_rx_status u_dut (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .rx_busy(rx_busy), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
        .rx_shift_flush_ff(rx_shift_flush_ff), .data_format_select_ff(fmt), .irq_ff(irq_ff));
    urs_far_tx u_far (.core_clk(core_clk), .rx_shift_flush_ff(rx_shift_flush_ff),
        .rx_busy(rx_busy), .rx_char_valid(rx_char_valid), .rx_char(rx_char));

    always #12.5 core_clk = ~core_clk;

    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
        samples_checked++;
        if (((g ^ e) & m) !== 32'h0) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : cmp

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // read results are judged against the oldest note; hang guard
    always @(posedge core_clk) begin
        if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) begin
            cmp("read data", exp_q.pop_front(), wb_dat_r, care_q.pop_front());
        end
        if (rx_shift_flush_ff === 1'b1) n_flush++;
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= w;
        wb_adr   <= a;
        wb_dat_w <= d;
        wb_sel   <= 4'hf;
        do begin
            @(posedge core_clk);
        end while (wb_ack !== 1'b1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        care_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic wctl(input logic [31:0] v);
        ctl = v & 32'hffff00e0;
        bus(1'b1, urs_pkg::OFS_STATUS_CONTROL, v);
    endtask : wctl

    function automatic logic [31:0] sts(input logic [4:0] f);
        return ctl | {27'h0, f};
    endfunction : sts

    task automatic push(input logic [8:0] d, input logic fe, input logic pe, input bit keep);
        if (keep) dq.push_back(d);
        u_far.frame('{framing_error_flag: fe, parity_error_flag: pe, data: d}, 1 + $urandom_range(3));
        repeat (2) @(posedge core_clk);
    endtask : push

    task automatic drain();
        while (dq.size() > 0) rd(urs_pkg::OFS_RX_DATA, {23'h0, dq.pop_front()}, 32'hffffffff);
    endtask : drain

    initial begin
        core_clk = 1'b0;
        rst_b    = 1'b0;
        wb_cyc   = 1'b0;
        wb_stb   = 1'b0;
        wb_we    = 1'b0;
        wb_adr   = 5'h00;
        wb_sel   = 4'h0;
        wb_dat_w = 32'h0;
        ctl      = 32'h0;
        void'($urandom(75737));
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd(urs_pkg::OFS_STATUS_CONTROL, 32'h10, 32'hffffffff);
        rd(urs_pkg::OFS_FORMAT, 32'h0, 32'hffffffff);
        rd(5'h14, 32'h0, 32'hffffffff);
        $display("test reset done");
        push(9'h011, 1'b1, 1'b0, 1'b1);
        push(9'h122, 1'b0, 1'b1, 1'b1);
        rd(urs_pkg::OFS_STATUS_CONTROL, 32'h5, 32'hf);
        rd(urs_pkg::OFS_IRQ_STATUS, 32'h9, 32'hf);
        rd(urs_pkg::OFS_RX_DATA, 32'h011, 32'hffffffff);
        rd(urs_pkg::OFS_STATUS_CONTROL, 32'h9, 32'hf);
        rd(urs_pkg::OFS_RX_DATA, 32'h122, 32'hffffffff);
        rd(urs_pkg::OFS_STATUS_CONTROL, 32'h10, 32'h1f);
        dq.delete();
        fork
            u_far.frame('{framing_error_flag: 1'b0, parity_error_flag: 1'b0, data: 9'h0a5}, 20);
            begin
                repeat (4) @(posedge core_clk);
                rd(urs_pkg::OFS_STATUS_CONTROL, 32'h0, 32'h10);
            end
        join
        repeat (2) @(posedge core_clk);
        rd(urs_pkg::OFS_STATUS_CONTROL, 32'h11, 32'h11);
        rd(urs_pkg::OFS_RX_DATA, 32'h0a5, 32'hffffffff);
        $display("test error and idle flags done");
        bus(1'b1, urs_pkg::OFS_IRQ_MASK, 32'h1);
        for (int k = 0; k < 3; k++) begin
            wctl(32'(k) << urs_pkg::ISEL_LSB);
            rd(urs_pkg::OFS_IRQ_STATUS, 32'(k == 0), 32'hf);
            repeat (k) push(9'($urandom), 1'b0, 1'b0, 1'b1);
            rd(urs_pkg::OFS_IRQ_STATUS, 32'h0, 32'h1);
            push(9'($urandom), 1'b0, 1'b0, 1'b1);
            repeat (3) @(posedge core_clk);
            cmp("level irq", 32'h1, {31'h0, irq_ff}, 32'h1);
            rd(urs_pkg::OFS_IRQ_STATUS, 32'h1, 32'h1);
            repeat (3) @(posedge core_clk);
            cmp("level irq", 32'h0, {31'h0, irq_ff}, 32'h1);
            drain();
        end
        wctl(32'h000000c0);
        rd(urs_pkg::OFS_IRQ_STATUS, 32'h0, 32'hf);
        push(9'($urandom), 1'b0, 1'b0, 1'b1);
        rd(urs_pkg::OFS_IRQ_STATUS, 32'h0, 32'hf);
        drain();
        $display("test level interrupt done");
        wctl(32'h0);
        repeat (5) push(9'($urandom), 1'b0, 1'b0, dq.size() < 4);
        rd(urs_pkg::OFS_STATUS_CONTROL, sts(5'h13), 32'hffffffff);
        rd(urs_pkg::OFS_IRQ_STATUS, 32'h4, 32'h4);
        bus(1'b1, urs_pkg::OFS_STATUS_CONTROL, ctl | 32'h2);
        rd(urs_pkg::OFS_STATUS_CONTROL, sts(5'h13), 32'hffffffff);
        n_flush = 0;
        bus(1'b1, urs_pkg::OFS_STATUS_CONTROL, ctl);
        repeat (3) @(posedge core_clk);
        cmp("flush pulses", 32'h1, 32'(n_flush), 32'hffffffff);
        rd(urs_pkg::OFS_STATUS_CONTROL, sts(5'h10), 32'hffffffff);
        rd(urs_pkg::OFS_RX_DATA, 32'h0, 32'hffffffff);
        dq.delete();
        $display("test overrun done");
        bus(1'b1, urs_pkg::OFS_FORMAT, 32'h3);
        rd(urs_pkg::OFS_FORMAT, 32'h3, 32'h3);
        wctl(32'hf0500020);
        rd(urs_pkg::OFS_IRQ_STATUS, 32'h0, 32'hf);
        for (int i = 0; i < 5; i++) push(atab[i][8:0], 1'b0, 1'b0, atab[i][9]);
        rd(urs_pkg::OFS_IRQ_STATUS, 32'h2, 32'h2);
        drain();
        bus(1'b1, urs_pkg::OFS_FORMAT, 32'h0);
        push(9'h066, 1'b0, 1'b0, 1'b1);
        drain();
        rd(urs_pkg::OFS_STATUS_CONTROL, sts(5'h10), 32'hffffffff);
        $display("test address detect done");
        wrap_up();
    end
endmodule : tb_top
